/* File: upso_bank.sv */
// APB register bank holding PHY session/vbus comparator tuning and overrides.
// Assumes a 40 MHz APB clock with synchronous active-low reset; outputs feed PHY analog pins.
//
// Functional notes
// - Each low data bit n is written only when write data bit n+16 is one.
// - A zero mask bit leaves the stored bit unchanged; the mask half is write-only and reads zero.
// - Bits 15 to 13 hold the session-end reference code, reset zero, driven to the PHY.
// - Bits 12 to 10 hold the B-session-valid reference code, reset zero, driven to the PHY.
// - Bits 9 to 7 hold the A-session-valid reference code, reset zero, driven to the PHY.
// - Bit 6 set forces the vbus_valid output asserted; reset zero.
// - Bit 5 set forces the session-end output asserted; reset zero.
// - Bit 4 set forces the B-session-valid output asserted; reset zero.
// - Bit 3 set forces the A-session-valid output asserted; reset zero.
// - Bit 2, active low and reset one, turns off the differential receiver in suspend when zero.
`timescale 1ns/1ps
`default_nettype none
`include "upso_regs.svh"
module upso_bank
  import upso_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // PHY comparator tuning and overrides
  output upso_phy_ctl_t o_phy_ctl
);
  logic [15:0] ovrd_q;
  logic [15:0] ovrd_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `UPSO_ADDR_RSVD5) || (a == `UPSO_ADDR_OVRD6);
  endfunction

  function automatic logic is_ovrd(input logic [11:0] a);
    is_ovrd = (a == `UPSO_ADDR_OVRD6);
  endfunction

  // Answer is registered: one setup cycle, then exactly one access cycle
  assign setup = i_psel && !i_penable;
  // Writes take effect only at the edge that closes the access cycle
  logic commit;
  assign commit = i_psel && i_penable && pready_q;

  upso_mask_write u_mask (
    .i_cur(ovrd_q),
    .i_rw_bits(`UPSO_OVRD_RWMASK),
    .i_wdata(i_pwdata),
    .o_next(ovrd_d)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ovrd_q <= `UPSO_OVRD_RESET;
    end else if (commit && i_pwrite && is_ovrd(i_paddr)) begin
      ovrd_q <= ovrd_d;
    end
  end

  // Answer flags pulse for the single access cycle that follows setup
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !addr_known(i_paddr);
    end
  end

  // Read data is zero outside the answer cycle, so a stale word never lingers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !i_pwrite && is_ovrd(i_paddr)) begin
      prdata_q <= {16'h0000, ovrd_q};
    end else begin
      prdata_q <= 32'h00000000;
    end
  end

  // Flop outputs so PHY analog pins never see decode glitches
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_phy_ctl.session_end_ref <= 3'h0;
      o_phy_ctl.b_session_ref <= 3'h0;
      o_phy_ctl.a_session_ref <= 3'h0;
      o_phy_ctl.force_vbus_valid <= 1'b0;
      o_phy_ctl.force_session_end <= 1'b0;
      o_phy_ctl.force_b_session <= 1'b0;
      o_phy_ctl.force_a_session <= 1'b0;
      o_phy_ctl.diff_rx_on_suspend <= 1'b1;
    end else begin
      o_phy_ctl.session_end_ref <= ovrd_q[`UPSO_SEND_MSB:`UPSO_SEND_LSB];
      o_phy_ctl.b_session_ref <= ovrd_q[`UPSO_BSES_MSB:`UPSO_BSES_LSB];
      o_phy_ctl.a_session_ref <= ovrd_q[`UPSO_ASES_MSB:`UPSO_ASES_LSB];
      o_phy_ctl.force_vbus_valid <= ovrd_q[`UPSO_FVBUS_BIT];
      o_phy_ctl.force_session_end <= ovrd_q[`UPSO_FSEND_BIT];
      o_phy_ctl.force_b_session <= ovrd_q[`UPSO_FBSES_BIT];
      o_phy_ctl.force_a_session <= ovrd_q[`UPSO_FASES_BIT];
      o_phy_ctl.diff_rx_on_suspend <= ovrd_q[`UPSO_RXOFF_BIT];
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

  logic wr6;
  assign wr6 = commit && i_pwrite && is_ovrd(i_paddr);

  masked_update_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[29] |=> ovrd_q[13] == $past(i_pwdata[13]))
    else $error("masked bit not written");
  mask_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && !i_pwdata[22] |=> $stable(ovrd_q[6]))
    else $error("unmasked bit changed");
  send_ref_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> o_phy_ctl.session_end_ref == $past(ovrd_q[15:13]))
    else $error("session end ref mismatch");
  bses_ref_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> o_phy_ctl.b_session_ref == $past(ovrd_q[12:10]))
    else $error("b session ref mismatch");
  ases_ref_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> o_phy_ctl.a_session_ref == $past(ovrd_q[9:7]))
    else $error("a session ref mismatch");
  force_vbus_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[22] |=> ##1 o_phy_ctl.force_vbus_valid == $past(i_pwdata[6], 2))
    else $error("vbus force not applied");
  force_send_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[21] |=> ##1 o_phy_ctl.force_session_end == $past(i_pwdata[5], 2))
    else $error("session end force not applied");
  force_bses_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_phy_ctl.force_b_session == $past(ovrd_q[4]))
    else $error("b session force mismatch");
  force_ases_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_phy_ctl.force_a_session == $past(ovrd_q[3]))
    else $error("a session force mismatch");
  rx_off_a: assert property (@(posedge i_clk)
    $rose(i_rstn) |-> ovrd_q[2] == 1'b1)
    else $error("rx control reset wrong");
  reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ovrd_q[1:0] == 2'b00 && o_prdata[31:16] == 16'h0000)
    else $error("reserved bits nonzero");

  // Bus answer timing
  ready_answer_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    setup |=> o_pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !setup |=> !o_pready)
    else $error("ready without setup");
  err_unmapped_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    setup && !addr_known(i_paddr) |=> o_pslverr)
    else $error("no error for unmapped address");
  err_mapped_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(setup && !addr_known(i_paddr)) |=> !o_pslverr)
    else $error("error on mapped address");
  err_with_ready_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_pslverr |-> o_pready)
    else $error("error without ready");

  // Read data
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_pready |-> o_prdata == 32'h00000000)
    else $error("read data outside answer");
  rdata_value_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    setup && !i_pwrite && is_ovrd(i_paddr) |=> o_prdata == {16'h0000, $past(ovrd_q)})
    else $error("override read data wrong");
  rdata_rsvd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    setup && !i_pwrite && i_paddr == `UPSO_ADDR_RSVD5 |=> o_prdata == 32'h00000000)
    else $error("reserved register reads nonzero");

  // Stored word and PHY control outputs
  other_write_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    commit && !(i_pwrite && is_ovrd(i_paddr)) |=> $stable(ovrd_q))
    else $error("stored word changed by other access");
  ovrd_reset_a: assert property (@(posedge i_clk)
    !i_rstn |=> ovrd_q == `UPSO_OVRD_RESET)
    else $error("stored word reset wrong");
  ctl_reset_a: assert property (@(posedge i_clk)
    !i_rstn |=> {o_phy_ctl, 2'b00} == `UPSO_OVRD_RESET)
    else $error("phy controls reset wrong");
  send_ref_top_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[31] |=> ovrd_q[15] == $past(i_pwdata[15]))
    else $error("session end ref top bit not written");
  bses_ref_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[26] |=> ovrd_q[10] == $past(i_pwdata[10]))
    else $error("b session ref not written");
  ases_ref_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[23] |=> ovrd_q[7] == $past(i_pwdata[7]))
    else $error("a session ref not written");
  ases_ref_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && !i_pwdata[23] |=> $stable(ovrd_q[7]))
    else $error("a session ref changed unmasked");
  send_force_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && !i_pwdata[21] |=> $stable(ovrd_q[5]))
    else $error("session end force changed unmasked");
  force_bses_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[20] |=> ##1 o_phy_ctl.force_b_session == $past(i_pwdata[4], 2))
    else $error("b session force not applied");
  force_ases_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[19] |=> ##1 o_phy_ctl.force_a_session == $past(i_pwdata[3], 2))
    else $error("a session force not applied");
  rx_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && i_pwdata[18] |=> ##1 o_phy_ctl.diff_rx_on_suspend == $past(i_pwdata[2], 2))
    else $error("rx control not applied");
  rx_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr6 && !i_pwdata[18] |=> $stable(ovrd_q[2]))
    else $error("rx control changed unmasked");
endmodule
`default_nettype wire

/* File: upso_mask_write.sv */
// Masked half-word write helper: upper 16 bits gate writes to the lower 16.
// Pure combinational; caller decides when the result is stored.
`timescale 1ns/1ps
`default_nettype none
module upso_mask_write (
  // Current value and writable bits
  input wire logic [15:0] i_cur,
  input wire logic [15:0] i_rw_bits,
  // Bus write data
  input wire logic [31:0] i_wdata,
  // Merged result
  output logic [15:0] o_next
);
  genvar n;
  generate
    for (n = 0; n < 16; n = n + 1) begin : g_bit
      // Mask half is never stored, only consulted
      assign o_next[n] = (i_wdata[n + 16] && i_rw_bits[n]) ? i_wdata[n] : i_cur[n];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: upso_phy_model.sv */
// Behavioural PHY session comparators fed by the override bank.
// Assumes the bench supplies raw detector levels: vbus, session end, B, A.
`timescale 1ns/1ps
`default_nettype none
module upso_phy_model
  import upso_pkg::*;
(
  // Override controls and raw detection
  input wire upso_phy_ctl_t i_ctl,
  input wire logic [3:0] i_det,
  // Seen comparator outputs
  output logic [3:0] o_seen
);
  // Forces win over detection, so a stuck force hides the real level
  assign o_seen = i_det | {i_ctl.force_vbus_valid, i_ctl.force_session_end,
    i_ctl.force_b_session, i_ctl.force_a_session};
endmodule
`default_nettype wire

/* File: upso_pkg.sv */
// Types for the PHY session override bank.
// Assumes nothing of its surroundings; the numeric constants live in upso_regs.svh.
`default_nettype none
package upso_pkg;
  typedef struct packed {
    logic [2:0] session_end_ref;
    logic [2:0] b_session_ref;
    logic [2:0] a_session_ref;
    logic force_vbus_valid;
    logic force_session_end;
    logic force_b_session;
    logic force_a_session;
    logic diff_rx_on_suspend;
  } upso_phy_ctl_t;
endpackage
`default_nettype wire

/* File: upso_regs.svh */
// Register offsets, field positions and reset values for the PHY session override bank.
// Included by the bank and bench files; definitions only.
`ifndef UPSO_REGS_SVH
`define UPSO_REGS_SVH
`define UPSO_ADDR_RSVD5 12'h294
`define UPSO_ADDR_OVRD6 12'h298
`define UPSO_MASK_LSB 16
`define UPSO_SEND_MSB 15
`define UPSO_SEND_LSB 13
`define UPSO_BSES_MSB 12
`define UPSO_BSES_LSB 10
`define UPSO_ASES_MSB 9
`define UPSO_ASES_LSB 7
`define UPSO_FVBUS_BIT 6
`define UPSO_FSEND_BIT 5
`define UPSO_FBSES_BIT 4
`define UPSO_FASES_BIT 3
`define UPSO_RXOFF_BIT 2
`define UPSO_OVRD_RESET 16'h0004
`define UPSO_OVRD_RWMASK 16'hFFFC
`endif

/* File: usb_phy_session_override_regs_test.sv */
// Self-checking bench for the PHY session override bank over APB.
// Assumes upso_regs.svh in the include path and the PHY model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "upso_regs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module usb_phy_session_override_regs_test;
  import upso_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_pslverr, err;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [15:0] model = 16'h0004, m, d;
  logic [3:0] det = 4'h0, seen;
  upso_phy_ctl_t o_phy_ctl;
  int bad_count = 0, samples_checked = 0;
  upso_bank uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_phy_ctl(o_phy_ctl));
  upso_phy_model phy (.i_ctl(o_phy_ctl), .i_det(det), .o_seen(seen));
  always #12.5 i_clk = ~i_clk;
  // Master waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic check_all();
    apb(1'b0, `UPSO_ADDR_OVRD6, 32'h0);
    `CHK(rd, {16'h0000, model})
    `CHK(err, 1'b0)
    `CHK({o_phy_ctl, 2'b00}, model)
    `CHK(seen, det | model[6:3])
  endtask
  task automatic wrap_up();
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(81));
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    check_all();
    apb(1'b0, `UPSO_ADDR_RSVD5, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err, 1'b0)
    for (int i = 0; i < 40; i++) begin
      // First two writes set then clear every writable bit, the rest are random masks
      m = (i < 2) ? 16'hFFFF : 16'($urandom);
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      det <= 4'($urandom);
      apb(1'b1, (i % 5 == 4) ? `UPSO_ADDR_RSVD5 : `UPSO_ADDR_OVRD6, {m, d});
      if (i % 5 != 4) model = (model & ~(m & 16'hFFFC)) | (d & m & 16'hFFFC);
      check_all();
    end
    apb(1'b0, `UPSO_ADDR_RSVD5, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err, 1'b0)
    apb(1'b1, 12'h2A0, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    check_all();
    // Set every writable bit, then reset mid-run and expect the reset word again
    apb(1'b1, `UPSO_ADDR_OVRD6, 32'hFFFFFFFF);
    model = 16'hFFFC;
    check_all();
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    model = 16'h0004;
    check_all();
    wrap_up();
  end
endmodule
`default_nettype wire
